//--- shared/afd_pkg.sv
// constants, field layouts and carrier types of the converter output path
// assumes one 125 MHz core clock and byte-wide internal register accesses
package afd_pkg;

    // ---------------------------------------------------------------
    // sample and register port widths
    // ---------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int ADDR_W   = 13;
    localparam int BYTE_W   = 8;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [12:0] OFS_PWR_MODE   = 13'h008;
    localparam logic [12:0] OFS_OUT_MODE   = 13'h014;
    localparam logic [12:0] OFS_DRIVE_CUR  = 13'h015;
    localparam logic [12:0] OFS_DCLK_DELAY = 13'h017;
    localparam logic [12:0] OFS_THR_CTRL   = 13'h045;
    localparam logic [12:0] OFS_THR_UPPER  = 13'h047;
    localparam logic [12:0] OFS_THR_LOW_L  = 13'h049;
    localparam logic [12:0] OFS_THR_LOW_H  = 13'h04a;
    localparam logic [12:0] OFS_DWELL_L    = 13'h04b;
    localparam logic [12:0] OFS_DWELL_H    = 13'h04c;
    localparam logic [12:0] OFS_TRANSFER   = 13'h0ff;

    // ---------------------------------------------------------------
    // fields and reset values
    // ---------------------------------------------------------------
    localparam int         THR_EN_BIT     = 0;
    localparam int         XFER_BIT       = 0;
    localparam logic [1:0] PWR_NORMAL     = 2'h0;
    localparam logic [1:0] PWR_DOWN       = 2'h1;
    localparam logic [7:0] RST_OUT_MODE   = 8'h01;
    localparam logic [7:0] RST_DRIVE_CUR  = 8'h00;
    localparam logic [4:0] RST_DCLK_DELAY = 5'h00;
    localparam logic [15:0] RST_DWELL     = 16'h0001;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int PIPE_LATENCY  = 26;   // sample clocks, input to output
    localparam int UPPER_LATENCY = 7;    // sample clocks, input to alert
    localparam int DCLK_STEPS    = 32;
    localparam int DCLK_STEP_PS  = 81;   // applied by the analog delay line
    localparam logic [15:0] TWOS_NEG_FS = 16'h8000;

    // output data formats
    typedef enum logic [1:0] {
        FMT_OFFSET = 2'h0,
        FMT_TWOS   = 2'h1,
        FMT_GRAY   = 2'h2
    } afd_fmt_t;

    // one converted sample with its overrange flag
    typedef struct packed {
        logic                over;
        logic [SAMPLE_W-1:0] data;
    } afd_sample_t;

    // per-channel threshold detector setup
    typedef struct packed {
        logic        enable;
        logic [3:0]  upper;
        logic [14:0] lower;
        logic [15:0] dwell;
    } afd_thr_cfg_t;

    // magnitude of a twos complement sample, most negative clamps
    function automatic logic [14:0] afd_magnitude(input logic [15:0] d);
        logic [15:0] neg;
        neg = ~d + 16'h0001;
        if (!d[15])
            return d[14:0];
        else if (neg[15])
            return 15'h7fff;
        else
            return neg[14:0];
    endfunction : afd_magnitude

endpackage : afd_pkg

//--- src/afd_fast_detect.sv
// one channel of the fast threshold detector
// assumes taps of the sample pipeline and a one-cycle sample strobe
`timescale 1ns/100ps
module afd_fast_detect (
    input  wire logic                 ref_clk,     // core clock
    input  wire logic                 rstn,        // async reset, low
    input  wire logic                 sampleValid, // one sample clock
    input  wire afd_pkg::afd_thr_cfg_t cfg,        // active setup
    input  wire logic [15:0]          earlyData,   // early pipeline tap
    input  wire logic [15:0]          lateData,    // end of pipeline
    output logic                      alert        // threshold alert
);
    import afd_pkg::*;

    logic [14:0] magEarly;
    logic [14:0] magLate;
    logic        upperHit;
    logic        belowLower;
    logic [15:0] dwellTarget;
    logic [16:0] dwellCntInc;
    logic [15:0] dwellCnt_reg;
    logic        alert_reg;

    // ---------------------------------------------------------------
    // comparisons, sign ignored
    // ---------------------------------------------------------------
    assign magEarly    = afd_magnitude(earlyData);
    assign magLate     = afd_magnitude(lateData);
    // upper step is one eighth of full scale
    assign upperHit    = {1'b0, magEarly} > {cfg.upper, 12'h000};
    assign belowLower  = magLate < cfg.lower;
    // a zero dwell behaves as one: cleared on the first sample below lower
    assign dwellTarget = (cfg.dwell == 16'h0000) ? 16'h0001 : cfg.dwell;
    assign dwellCntInc = {1'b0, dwellCnt_reg} + 17'h00001;

    // set by the upper compare, cleared after dwell below lower
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            alert_reg    <= 1'b0;
            dwellCnt_reg <= 16'h0000;
        end else if (!cfg.enable) begin
            alert_reg    <= 1'b0;
            dwellCnt_reg <= 16'h0000;
        end else if (sampleValid) begin
            if (upperHit) begin
                alert_reg    <= 1'b1;
                dwellCnt_reg <= 16'h0000;
            end else if (alert_reg && belowLower) begin
                if (dwellCntInc >= {1'b0, dwellTarget}) begin
                    alert_reg    <= 1'b0;
                    dwellCnt_reg <= 16'h0000;
                end else begin
                    dwellCnt_reg <= dwellCntInc[15:0];
                end
            end else begin
                dwellCnt_reg <= 16'h0000;
            end
        end
    end

    assign alert = alert_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_thr_disabled: assert property (@(posedge ref_clk) disable iff (!rstn)
        !cfg.enable |=> !alert_reg)
        else $error("alert high while detector disabled");
    a_upper_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
        sampleValid && cfg.enable && upperHit |=> alert_reg)
        else $error("upper crossing did not raise alert");
    a_rise_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
        $rose(alert_reg) |-> $past(upperHit && sampleValid))
        else $error("alert rose without an upper crossing");
    a_dwell_restart: assert property (@(posedge ref_clk)
        disable iff (!rstn)
        sampleValid && cfg.enable && alert_reg && !belowLower
        |=> alert_reg && dwellCnt_reg == 16'h0000)
        else $error("dwell did not restart above lower");

endmodule : afd_fast_detect

//--- src/afd_output_path.sv
// output path of a dual converter: latency pipe, formatting, ddr
// assumes samples arrive at most every second core clock, and byte
// register accesses from the serial port logic on the same clock
`timescale 1ns/100ps
module afd_output_path (
    input  wire logic                 ref_clk,     // 125 MHz core clock
    input  wire logic                 rstn,        // async reset, low
    input  wire logic                 sampleValid, // one pair of samples
    input  wire afd_pkg::afd_sample_t sampleA,     // channel a sample
    input  wire afd_pkg::afd_sample_t sampleB,     // channel b sample
    input  wire logic                 power_down_pin, // pin, async
    input  wire logic                 regWr,       // register write strobe
    input  wire logic [12:0]          regAddr,     // register offset
    input  wire logic [7:0]           regWrData,   // write byte
    input  wire logic [1:0]           chanSel,     // local channel select
    output logic [7:0]                regRdData,   // read byte, registered
    output logic [15:0]               dataOut,     // ddr output word
    output logic                      overOut,     // overrange flag
    output logic                      data_clock_out, // forwarded clock
    output logic                      outOe,       // output enable, high
    output logic                      threshold_alert_chan_a, // alert a
    output logic                      threshold_alert_chan_b, // alert b
    output logic [4:0]                dclkDelay,   // delay line setting
    output logic [7:0]                driveCurrent // driver current code
);
    import afd_pkg::*;

    typedef enum logic [1:0] {PH_IDLE, PH_B} afd_phase_t;

    afd_sample_t  pipe_reg [2][PIPE_LATENCY];
    afd_sample_t  holdB_reg;
    afd_thr_cfg_t thrShadow_reg [2];
    afd_thr_cfg_t thrActive_reg [2];
    logic [1:0]   alertVec;
    logic [1:0]   alert_reg;
    logic [1:0]   pwrShadow_reg;
    logic [1:0]   pwrActive_reg;
    logic [1:0]   fmtShadow_reg;
    afd_fmt_t     fmtActive_reg;
    logic [7:0]   drive_reg;
    logic [4:0]   dclkDelay_reg;
    logic         xfer_reg;
    logic         pdSync1_reg;
    logic         pdSync2_reg;
    logic         powerDown;
    afd_phase_t   phase_reg;
    logic [15:0]  dataOut_reg;
    logic         overOut_reg;
    logic         dclk_reg;
    logic         outOe_reg;
    logic [7:0]   regRdData_reg;
    logic         rdSel;
    afd_sample_t  sampleIn [2];

    // formats one twos complement word for the output pins
    function automatic logic [15:0] fmtWord(input logic [15:0] d,
                                            input afd_fmt_t m);
        logic [15:0] ob;
        ob = {~d[15], d[14:0]};
        unique case (m)
            FMT_TWOS:   return d;
            FMT_OFFSET: return ob;
            FMT_GRAY:   return ob ^ (ob >> 1);
            default:    return d;
        endcase
    endfunction : fmtWord

    assign sampleIn[0] = sampleA;
    assign sampleIn[1] = sampleB;

    // ---------------------------------------------------------------
    // per-channel pipeline and threshold detector
    // ---------------------------------------------------------------
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            // sample and overrange travel together, one stage per sample
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    for (int i = 0; i < PIPE_LATENCY; i++) begin
                        pipe_reg[ch][i] <= '0;
                    end
                end else if (sampleValid) begin
                    pipe_reg[ch][0] <= sampleIn[ch];
                    for (int i = 1; i < PIPE_LATENCY; i++) begin
                        pipe_reg[ch][i] <= pipe_reg[ch][i-1];
                    end
                end
            end

            // independent detector for each channel
            afd_fast_detect u_detect (
                .ref_clk     (ref_clk),
                .rstn        (rstn),
                .sampleValid (sampleValid),
                .cfg         (thrActive_reg[ch]),
                .earlyData   (pipe_reg[ch][UPPER_LATENCY-2].data),
                .lateData    (pipe_reg[ch][PIPE_LATENCY-1].data),
                .alert       (alertVec[ch])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    // local registers go to each selected channel; globals ignore chanSel
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < 2; c++) begin
                thrShadow_reg[c] <= '{1'b0, 4'h0, 15'h0000, RST_DWELL};
            end
            pwrShadow_reg <= PWR_NORMAL;
            fmtShadow_reg <= RST_OUT_MODE[1:0];
            drive_reg     <= RST_DRIVE_CUR;
            dclkDelay_reg <= RST_DCLK_DELAY;
        end else if (regWr) begin
            for (int c = 0; c < 2; c++) begin
                if (chanSel[c]) begin
                    unique case (regAddr)
                        OFS_THR_CTRL:  thrShadow_reg[c].enable
                                           <= regWrData[THR_EN_BIT];
                        OFS_THR_UPPER: thrShadow_reg[c].upper
                                           <= regWrData[3:0];
                        OFS_THR_LOW_L: thrShadow_reg[c].lower[7:0]
                                           <= regWrData;
                        OFS_THR_LOW_H: thrShadow_reg[c].lower[14:8]
                                           <= regWrData[6:0];
                        OFS_DWELL_L:   thrShadow_reg[c].dwell[7:0]
                                           <= regWrData;
                        OFS_DWELL_H:   thrShadow_reg[c].dwell[15:8]
                                           <= regWrData;
                        default: ;
                    endcase
                end
            end
            unique case (regAddr)
                OFS_PWR_MODE:   pwrShadow_reg <= regWrData[1:0];
                OFS_OUT_MODE:   fmtShadow_reg <= regWrData[1:0];
                OFS_DRIVE_CUR:  drive_reg     <= regWrData;
                OFS_DCLK_DELAY: dclkDelay_reg <= regWrData[4:0];
                default: ;
            endcase
        end
    end

    // transfer bit lives for one cycle, so it reads back set for only one cycle after the write
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            xfer_reg <= 1'b0;
        end else begin
            xfer_reg <= regWr && regAddr == OFS_TRANSFER
                        && regWrData[XFER_BIT];
        end
    end

    // shadow copies move to the working set all at once
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < 2; c++) begin
                thrActive_reg[c] <= '{1'b0, 4'h0, 15'h0000, RST_DWELL};
            end
            pwrActive_reg <= PWR_NORMAL;
            fmtActive_reg <= afd_fmt_t'(RST_OUT_MODE[1:0]);
        end else if (xfer_reg) begin
            thrActive_reg <= thrShadow_reg;
            pwrActive_reg <= pwrShadow_reg;
            fmtActive_reg <= afd_fmt_t'(fmtShadow_reg);
        end
    end

    // readback shows the shadow values; channel a wins if both selected
    assign rdSel = !chanSel[0];
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            regRdData_reg <= 8'h00;
        end else begin
            unique case (regAddr)
                OFS_PWR_MODE:   regRdData_reg <= {6'h00, pwrShadow_reg};
                OFS_OUT_MODE:   regRdData_reg <= {6'h00, fmtShadow_reg};
                OFS_DRIVE_CUR:  regRdData_reg <= drive_reg;
                OFS_DCLK_DELAY: regRdData_reg <= {3'h0, dclkDelay_reg};
                OFS_THR_CTRL:   regRdData_reg <=
                    {7'h00, thrShadow_reg[rdSel].enable};
                OFS_THR_UPPER:  regRdData_reg <=
                    {4'h0, thrShadow_reg[rdSel].upper};
                OFS_THR_LOW_L:  regRdData_reg <=
                    thrShadow_reg[rdSel].lower[7:0];
                OFS_THR_LOW_H:  regRdData_reg <=
                    {1'b0, thrShadow_reg[rdSel].lower[14:8]};
                OFS_DWELL_L:    regRdData_reg <=
                    thrShadow_reg[rdSel].dwell[7:0];
                OFS_DWELL_H:    regRdData_reg <=
                    thrShadow_reg[rdSel].dwell[15:8];
                OFS_TRANSFER:   regRdData_reg <= {7'h00, xfer_reg};
                default:        regRdData_reg <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // power-down
    // ---------------------------------------------------------------
    // the pin is asynchronous to the core clock
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pdSync1_reg <= 1'b0;
            pdSync2_reg <= 1'b0;
        end else begin
            pdSync1_reg <= power_down_pin;
            pdSync2_reg <= pdSync1_reg;
        end
    end

    assign powerDown = pdSync2_reg || pwrActive_reg == PWR_DOWN;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            outOe_reg <= 1'b0;
        end else begin
            outOe_reg <= !powerDown;
        end
    end

    // ---------------------------------------------------------------
    // ddr output: channel a with the rising clock, b with the falling
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase_reg   <= PH_IDLE;
            dataOut_reg <= 16'h0000;
            overOut_reg <= 1'b0;
            dclk_reg    <= 1'b0;
            holdB_reg   <= '0;
            alert_reg   <= 2'b00;
        end else begin
            alert_reg <= alertVec;
            unique case (phase_reg)
                PH_IDLE: begin
                    if (sampleValid) begin
                        dataOut_reg <= fmtWord(
                            pipe_reg[0][PIPE_LATENCY-1].data, fmtActive_reg);
                        overOut_reg <= pipe_reg[0][PIPE_LATENCY-1].over;
                        holdB_reg   <= pipe_reg[1][PIPE_LATENCY-1];
                        dclk_reg    <= 1'b1;
                        phase_reg   <= PH_B;
                    end
                end
                PH_B: begin
                    // b word was caught before the pipe moved on
                    dataOut_reg <= fmtWord(holdB_reg.data, fmtActive_reg);
                    overOut_reg <= holdB_reg.over;
                    dclk_reg    <= 1'b0;
                    phase_reg   <= PH_IDLE;
                end
            endcase
        end
    end

    assign dataOut                = dataOut_reg;
    assign overOut                = overOut_reg;
    assign data_clock_out         = dclk_reg;
    assign outOe                  = outOe_reg;
    assign threshold_alert_chan_a = alert_reg[0];
    assign threshold_alert_chan_b = alert_reg[1];
    assign dclkDelay              = dclkDelay_reg;
    assign driveCurrent           = drive_reg;
    assign regRdData              = regRdData_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_word_pair;
        data_clock_out ##1 !data_clock_out;
    endsequence

    a_pd_hiz: assert property (@(posedge ref_clk) disable iff (!rstn)
        powerDown |=> !outOe)
        else $error("outputs driven during power-down");
    a_ddr_edges: assert property (@(posedge ref_clk) disable iff (!rstn)
        sampleValid && phase_reg == PH_IDLE |=> s_word_pair)
        else $error("data clock did not toggle around the pair");
    a_over_align: assert property (@(posedge ref_clk) disable iff (!rstn)
        sampleValid && phase_reg == PH_IDLE
        |=> overOut == $past(pipe_reg[0][PIPE_LATENCY-1].over))
        else $error("overrange not aligned with its word");
    a_twos_negfs: assert property (@(posedge ref_clk) disable iff (!rstn)
        sampleValid && phase_reg == PH_IDLE && fmtActive_reg == FMT_TWOS
        && pipe_reg[0][PIPE_LATENCY-1].data == TWOS_NEG_FS
        |=> dataOut == TWOS_NEG_FS)
        else $error("twos complement full scale wrong");
    a_xfer_apply: assert property (@(posedge ref_clk) disable iff (!rstn)
        xfer_reg |=> fmtActive_reg == $past(fmtShadow_reg)
        && pwrActive_reg == $past(pwrShadow_reg))
        else $error("transfer did not load working copies");
    a_xfer_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
        xfer_reg && !regWr |=> !xfer_reg)
        else $error("transfer bit did not clear itself");
    a_pd_pin: assert property (@(posedge ref_clk) disable iff (!rstn)
        power_down_pin [*3] |=> !outOe)
        else $error("power-down pin ignored");

endmodule : afd_output_path

//--- test/afd_capture_model.sv
// ddr capture register standing after the output path
// assumes the forwarded clock is sampled by the core clock
`timescale 1ns/100ps
module afd_capture_model (
    input  wire logic        clk,  // core clock
    input  wire logic        dclk, // forwarded data clock
    input  wire logic        over, // overrange flag
    input  wire logic [15:0] data, // ddr word
    output logic      [16:0] capA, // word taken on rising edge
    output logic      [16:0] capB  // word taken on falling edge
);
    logic dclkReg;
    // capture on both edges, so a late b word is never mistaken for a
    always_ff @(posedge clk) begin
        dclkReg <= dclk;
        if (dclk && !dclkReg) capA <= {over, data};
        if (!dclk && dclkReg) capB <= {over, data};
    end
endmodule : afd_capture_model

//--- test/afd_output_path_bench.sv
// bench for the output path: registers, samples, alerts, power
// assumes the capture model beside the design
`timescale 1ns/100ps
module afd_output_path_bench;
    import afd_pkg::*;
    logic ref_clk, rstn, sampleValid, power_down_pin, regWr, overOut;
    logic data_clock_out, outOe;
    logic threshold_alert_chan_a, threshold_alert_chan_b;
    afd_sample_t sampleA, sampleB;
    logic [12:0] regAddr;
    logic [7:0] regWrData, regRdData, driveCurrent;
    logic [1:0] chanSel;
    logic [15:0] dataOut;
    logic [4:0] dclkDelay;
    logic [16:0] capA, capB, hist[30];
    int fails, checked;
    afd_output_path dut (.ref_clk, .rstn, .sampleValid, .sampleA,
        .sampleB, .power_down_pin, .regWr, .regAddr, .regWrData, .chanSel,
        .regRdData, .dataOut, .overOut, .data_clock_out, .outOe,
        .threshold_alert_chan_a, .threshold_alert_chan_b, .dclkDelay,
        .driveCurrent);
    afd_capture_model cap (.clk(ref_clk), .dclk(data_clock_out),
        .over(overOut), .data(dataOut), .capA, .capB);
    task automatic cmp(input logic [16:0] got, exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // every task starts and ends just after a rising edge
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(posedge ref_clk) #1 regWr = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : wr
    task automatic rd(input logic [12:0] a, input logic [7:0] d);
        regAddr = a;
        repeat (2) @(posedge ref_clk);
        #1 cmp({9'h0, regRdData}, {9'h0, d});
    endtask : rd
    // strobes are four cycles apart, above the two-cycle minimum
    task automatic send(input logic [16:0] a, b);
        sampleA = a;
        sampleB = b;
        sampleValid = 1'b1;
        @(posedge ref_clk) #1 sampleValid = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : send
    task automatic print_verdict();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // watchdog well beyond the roughly 520 cycles of the tests
    initial begin
        #200000 fails++;
        print_verdict();
    end
    initial begin
        {rstn, sampleValid, power_down_pin, regWr} = 4'h0;
        {sampleA, sampleB, regAddr, regWrData} = '0;
        chanSel = 2'h3;
        repeat (6) @(posedge ref_clk);
        #1 rstn = 1'b1;
        rd(OFS_OUT_MODE, 8'h01);
        wr(OFS_DRIVE_CUR, 8'h05);
        wr(OFS_DCLK_DELAY, 8'h1f);
        cmp({9'h0, driveCurrent}, 17'h5);
        cmp({12'h0, dclkDelay}, 17'h1f);
        $display("registers done");
        for (int i = 0; i < 30; i++) begin
            // the first word is negative full scale, seen again at i == 26
            hist[i] = {i[0], 16'(i * 1663) ^ TWOS_NEG_FS};
            send(hist[i], ~hist[i]);
            if (i > 25) cmp(capA, hist[i-26]);
            if (i > 25) cmp(capB, ~hist[i-26]);
        end
        wr(OFS_OUT_MODE, 8'h00);
        wr(OFS_TRANSFER, 8'h01);
        rd(OFS_TRANSFER, 8'h00);
        repeat (27) send(17'h18000, 17'h07fff);
        cmp(capA, 17'h10000);
        cmp(capB, 17'h0ffff);
        // gray applies at the output, so the words already in the pipe serve
        wr(OFS_OUT_MODE, 8'h02);
        wr(OFS_TRANSFER, 8'h01);
        send(17'h18000, 17'h07fff);
        cmp(capA, 17'h10000);
        cmp(capB, 17'h08000);
        $display("samples done");
        // only channel a is armed: the pipe still holds full-scale words,
        // which would otherwise set channel b as well
        chanSel = 2'h1;
        wr(OFS_THR_UPPER, 8'h04);
        wr(OFS_THR_LOW_H, 8'h30);
        wr(OFS_DWELL_L, 8'h02);
        wr(OFS_THR_CTRL, 8'h01);
        rd(OFS_THR_UPPER, 8'h04);
        chanSel = 2'h2;
        rd(OFS_THR_UPPER, 8'h00);
        wr(OFS_TRANSFER, 8'h01);
        repeat (8) send(17'h0b000, 17'h01000);
        cmp({threshold_alert_chan_a, threshold_alert_chan_b}, 17'h2);
        repeat (20) send(17'h01000, 17'h01000);
        cmp({16'h0, threshold_alert_chan_a}, 17'h1);
        repeat (20) send(17'h01000, 17'h01000);
        cmp({16'h0, threshold_alert_chan_a}, 17'h0);
        $display("alerts done");
        wr(OFS_PWR_MODE, 8'h01);
        wr(OFS_TRANSFER, 8'h01);
        cmp({16'h0, outOe}, 17'h0);
        wr(OFS_PWR_MODE, 8'h00);
        wr(OFS_TRANSFER, 8'h01);
        power_down_pin = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        cmp({16'h0, outOe}, 17'h0);
        $display("power done");
        print_verdict();
    end
endmodule : afd_output_path_bench
